// [hdl/fpp_policy.sv]
// power-state policy gating for a bus function in D0..D3hot/D3cold
`timescale 1ns/1ps
`include "fpp_defines.svh"
module fpp_policy import fpp_pkg::*; #(
  parameter int D2_RECOVERY_CYC = `FPP_D2_RECOVERY_CYC,
  parameter int D3_RECOVERY_CYC = `FPP_D3_RECOVERY_CYC,
  parameter int CLK_HOLD_CYC = `FPP_CLK_HOLD_CYC,
  parameter bit PME_IN_D2 = 1'b1,
  parameter bit PME_IN_D3HOT = 1'b1,
  parameter bit PME_IN_D3COLD = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PWR_WR,
  input wire logic [1:0] PWR_WDATA,
  input wire logic AUX_ONLY,
  input wire logic IO_MEM_HIT,
  input wire logic CFG_HIT,
  input wire logic IRQ_REQ,
  input wire logic PME_REQ,
  input wire logic MASTER_REQ,
  output logic [1:0] FUNCTION_POWER_LEVEL_FIELD,
  output logic TARGET_CLAIM,
  output logic CFG_CLAIM,
  output logic IRQ_OUT,
  output logic PME_OUT,
  output logic MASTER_GRANT,
  output logic RECOVERY_BUSY,
  output logic CLK_STOP_OK
);
  localparam int TW = 32;

  fpp_dstate_t state_q;
  fpp_gate_t gate;
  logic recov_load;
  logic [TW-1:0] recov_val;
  logic [4:0] hold_q;
  logic stop_ok_q;
  logic pme_q;
  logic pme_sup;
  logic aux_s1_q;
  logic aux_s2_q;
  logic aux_s3_q;
  logic aux_q;

  // recovery length for a change between two states
  function automatic logic [TW-1:0] recov_cycles(input fpp_dstate_t from_s, input fpp_dstate_t to_s);
    if (from_s == FPP_D3HOT || to_s == FPP_D3HOT) begin
      recov_cycles = TW'(D3_RECOVERY_CYC);
    end else if (from_s == FPP_D2 || to_s == FPP_D2) begin
      recov_cycles = TW'(D2_RECOVERY_CYC);
    end else begin
      recov_cycles = '0;
    end
  endfunction

  // programmed power level, taken straight from each field write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= fpp_dstate_t'(`FPP_STATE_RESET);
    end else if (PWR_WR) begin
      state_q <= fpp_dstate_t'(PWR_WDATA);
    end
  end

  assign FUNCTION_POWER_LEVEL_FIELD = state_q;

  // aux-only level is a pin from the slot supply, so it is synchronised
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aux_s1_q <= 1'b0;
      aux_s2_q <= 1'b0;
      aux_s3_q <= 1'b0;
      aux_q <= 1'b0;
    end else begin
      aux_s1_q <= AUX_ONLY;
      aux_s2_q <= aux_s1_q;
      aux_s3_q <= aux_s2_q;
      if (aux_s2_q == aux_s3_q) begin
        aux_q <= aux_s3_q;
      end
    end
  end

  // every write restarts recovery, including a rewrite of the same level
  assign recov_load = PWR_WR;
  assign recov_val = recov_cycles(state_q, fpp_dstate_t'(PWR_WDATA));

  fpp_recovery_timer #(
    .WIDTH(TW)
  ) u_recov (
    .clk(CLK),
    .rst_n(RST_N),
    .load(recov_load),
    .load_val(recov_val),
    .busy(RECOVERY_BUSY)
  );

  // advisory only: software must honour it for config cycles too

  // gating straight from the current level
  always_comb begin
    gate.cfg_en = ~aux_q;
    gate.target_en = (state_q == FPP_D0) & ~aux_q;
    gate.irq_en = (state_q == FPP_D0) & ~aux_q;
    gate.master_en = (state_q == FPP_D0) & ~aux_q;
    if (aux_q) begin
      pme_sup = PME_IN_D3COLD;
    end else begin
      unique case (state_q)
        FPP_D2: pme_sup = PME_IN_D2;
        FPP_D3HOT: pme_sup = PME_IN_D3HOT;
        default: pme_sup = 1'b1;
      endcase
    end
    gate.pme_en = pme_sup;
  end

  assign TARGET_CLAIM = IO_MEM_HIT & gate.target_en;
  assign CFG_CLAIM = CFG_HIT & gate.cfg_en;
  assign IRQ_OUT = IRQ_REQ & gate.irq_en;
  assign MASTER_GRANT = MASTER_REQ & gate.master_en;

  // registered pme request, dropped one clock after it stops being allowed
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pme_q <= 1'b0;
    end else begin
      pme_q <= PME_REQ & gate.pme_en;
    end
  end

  assign PME_OUT = pme_q;

  // counts clocks after entering D2/D3hot; bus may be stopped after 16
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_q <= '0;
      stop_ok_q <= 1'b0;
    end else if (PWR_WR) begin
      hold_q <= '0;
      stop_ok_q <= 1'b0;
    end else if (state_q == FPP_D2 || state_q == FPP_D3HOT) begin
      if (32'(hold_q) < CLK_HOLD_CYC) begin
        hold_q <= hold_q + 5'h1;
      end
      stop_ok_q <= (32'(hold_q) + 1 >= CLK_HOLD_CYC);
    end else begin
      stop_ok_q <= 1'b0;
    end
  end

  assign CLK_STOP_OK = stop_ok_q;
endmodule

// [hdl/fpp_defines.svh]
// constants for the function power-state policy block
// Overview of operation
// - D2/D3hot: ignore memory/io, interrupt held off
// - D1/D2/D3hot: configuration accesses accepted unless the supply is aux-only
// - D2/D3: only PME initiated, if supported
// - recovery counted from last power-state write
`ifndef FPP_DEFINES_SVH
`define FPP_DEFINES_SVH
`define FPP_CLK_MHZ 250
`define FPP_D2_RECOVERY_US 200
`define FPP_D3_RECOVERY_MS 10
`define FPP_D2_RECOVERY_CYC (`FPP_D2_RECOVERY_US * `FPP_CLK_MHZ)
`define FPP_D3_RECOVERY_CYC (`FPP_D3_RECOVERY_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_CLK_HOLD_CYC 16
`define FPP_STATE_RESET 2'h0
`endif

// [hdl/fpp_pkg.sv]
// types for the function power-state policy block
package fpp_pkg;
  typedef enum logic [1:0] {
    FPP_D0 = 2'b00,
    FPP_D1 = 2'b01,
    FPP_D2 = 2'b10,
    FPP_D3HOT = 2'b11
  } fpp_dstate_t;
  typedef struct packed {
    logic target_en;
    logic cfg_en;
    logic irq_en;
    logic pme_en;
    logic master_en;
  } fpp_gate_t;
endpackage

// [hdl/fpp_recovery_timer.sv]
// down-counter timing the recovery interval after a power-state write
`timescale 1ns/1ps
module fpp_recovery_timer #(
  parameter int WIDTH = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic busy
);
  logic [WIDTH-1:0] cnt_q;

  // each load restarts the count, so the latest write governs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = (cnt_q != '0);
endmodule

// [sim/fpp_host_model.sv]
// host side model that writes the power level and honours recovery
`timescale 1ns/1ps
module fpp_host_model (
  input wire logic clk,
  input wire logic busy,
  output logic wr,
  output logic [1:0] wdata
);
  initial begin
    wr = 0;
    wdata = 2'h0;
  end
  // one-cycle write; wt holds later accesses off until recovery ends
  task automatic put(input logic [1:0] lv, input bit wt);
    int n;
    n = 0;
    @(negedge clk);
    wr = 1;
    wdata = lv;
    @(negedge clk);
    wr = 0;
    wdata = ~lv;
    while (wt && busy && n < 200) begin
      n++;
      @(negedge clk);
    end
  endtask
endmodule

// [sim/fpp_policy_chk.sv]
// assertions on the power-state policy ports
`timescale 1ns/1ps
module fpp_chk import fpp_pkg::*; #(
  parameter int D2_RECOVERY_CYC = 20,
  parameter int D3_RECOVERY_CYC = 50
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PWR_WR,
  input wire logic [1:0] PWR_WDATA,
  input wire logic AUX_ONLY,
  input wire logic CFG_HIT,
  input wire logic PME_REQ,
  input wire logic [1:0] FUNCTION_POWER_LEVEL_FIELD,
  input wire logic TARGET_CLAIM,
  input wire logic CFG_CLAIM,
  input wire logic IRQ_OUT,
  input wire logic PME_OUT,
  input wire logic MASTER_GRANT,
  input wire logic RECOVERY_BUSY
);
  wire [1:0] lv = FUNCTION_POWER_LEVEL_FIELD;
  int cnt_q;
  int lim_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // window length fixed at each write from old and new level, so a rewrite restarts it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= 0;
      lim_q <= 0;
    end else if (PWR_WR) begin
      cnt_q <= 0;
      lim_q <= (lv == 3 || PWR_WDATA == 3) ? D3_RECOVERY_CYC : (lv[1] || PWR_WDATA[1]) ? D2_RECOVERY_CYC : 0;
    end else if (cnt_q < lim_q) begin
      cnt_q <= cnt_q + 1;
    end
  end
  // the aux pin passes a synchroniser, so wait until it has settled
  sequence aux_off;
    !AUX_ONLY [*6];
  endsequence
  gate_low_a: assert property (lv[1] |-> !TARGET_CLAIM && !IRQ_OUT) else $error("claim open in low state");
  cfg_open_a: assert property (aux_off ##0 CFG_HIT |-> CFG_CLAIM) else $error("config access dropped");
  no_master_a: assert property (lv[1] |-> !MASTER_GRANT) else $error("master grant in low state");
  pme_pass_a: assert property (aux_off ##0 PME_REQ |=> PME_OUT) else $error("wake event lost");
  cold_mute_a: assert property (AUX_ONLY [*6] |-> !TARGET_CLAIM && !CFG_CLAIM && !IRQ_OUT) else $error("cold claim");
  level_load_a: assert property (PWR_WR |=> lv == $past(PWR_WDATA)) else $error("level not loaded");
  busy_span_a: assert property (RECOVERY_BUSY == (cnt_q < lim_q)) else $error("recovery span wrong");
endmodule
bind fpp_policy fpp_chk #(.D2_RECOVERY_CYC(D2_RECOVERY_CYC), .D3_RECOVERY_CYC(D3_RECOVERY_CYC)) chk (.*);

// [sim/fpp_policy_bench.sv]
// self-checking bench for the power-state policy block
`timescale 1ns/1ps
module fpp_policy_bench import fpp_pkg::*;;
  logic CLK = 0, RST_N = 0, AUX_ONLY = 0, hit = 1;
  logic PWR_WR, RECOVERY_BUSY, TARGET_CLAIM, CFG_CLAIM, IRQ_OUT, PME_OUT, MASTER_GRANT;
  logic [1:0] PWR_WDATA, lv;
  logic stop_ok;
  int error_cnt = 0, check_count = 0;
  always #2 CLK = ~CLK;
  fpp_host_model host (.clk(CLK), .busy(RECOVERY_BUSY), .wr(PWR_WR), .wdata(PWR_WDATA));
  // short recovery counts keep the run brief
  fpp_policy #(.D2_RECOVERY_CYC(20), .D3_RECOVERY_CYC(50)) uut (.CLK, .RST_N, .PWR_WR, .PWR_WDATA,
    .AUX_ONLY, .IO_MEM_HIT(hit), .CFG_HIT(hit), .IRQ_REQ(hit), .PME_REQ(hit), .MASTER_REQ(hit),
    .FUNCTION_POWER_LEVEL_FIELD(lv), .TARGET_CLAIM, .CFG_CLAIM, .IRQ_OUT, .PME_OUT, .MASTER_GRANT,
    .RECOVERY_BUSY, .CLK_STOP_OK(stop_ok));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // each level: below D0 only configuration and wake stay open
  task automatic t_levels();
    for (int i = 0; i < 4; i++) begin
      host.put(i[1:0], 1);
      chk("level", i, lv);
      chk("target", i == 0, TARGET_CLAIM);
      chk("irq", i == 0, IRQ_OUT);
      chk("master", i == 0, MASTER_GRANT);
      chk("cfg", 1, CFG_CLAIM);
      chk("pme", 1, PME_OUT);
    end
  endtask
  task automatic span(input logic [1:0] l, input int e);
    int n;
    n = 0;
    host.put(l, 0);
    while (RECOVERY_BUSY === 1 && n < 200) begin
      n++;
      @(negedge CLK);
    end
    chk("busy span", e, n);
  endtask
  // spans per transition; a rewrite mid-window restarts the count
  task automatic t_busy();
    span(2'h2, 50);
    host.put(2'h3, 0);
    repeat (10) @(negedge CLK);
    span(2'h0, 50);
    span(2'h1, 0);
  endtask
  // aux-only supply: only a PME request reaches the function
  task automatic t_cold();
    AUX_ONLY = 1;
    repeat (6) @(negedge CLK);
    chk("cold target", 0, TARGET_CLAIM);
    chk("cold cfg", 0, CFG_CLAIM);
    chk("cold irq", 0, IRQ_OUT);
    chk("cold pme", 1, PME_OUT);
    AUX_ONLY = 0;
    repeat (6) @(negedge CLK);
    chk("warm cfg", 1, CFG_CLAIM);
  endtask
  // bus clock may only be stopped once 16 clocks have passed in D2
  task automatic t_stop();
    host.put(2'h2, 0);
    repeat (15) @(negedge CLK);
    chk("stop early", 0, stop_ok);
    @(negedge CLK);
    chk("stop ok", 1, stop_ok);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge CLK);
    RST_N = 1;
    t_levels();
    t_busy();
    t_cold();
    t_stop();
    conclude();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #12000;
    error_cnt++;
    conclude();
  end
endmodule
